/* hdl/agoc_pkg.sv */
// Constants, register map and encodings for the ADC calibration register set.
// Assumes a 32-bit classic Wishbone bus with byte addresses.
package agoc_pkg;
	localparam int          DATA_W        = 32;
	localparam int          SAMPLE_W      = 16;
	localparam int          CAL_W         = 15;
	localparam int          FRAC_BITS     = 14;
	localparam int          QTR_BITS      = 2;
	localparam int          SCALE_SH      = FRAC_BITS + QTR_BITS;
	localparam int          EXT_W         = SAMPLE_W + QTR_BITS + 2;
	localparam int          PROD_W        = EXT_W + CAL_W + 2;
	localparam int          LANE_W        = 8;

	localparam logic [31:0] ADDR_GAIN_X4  = 32'h0000_2278;
	localparam logic [31:0] ADDR_OFF_X9   = 32'h0000_22D0;
	localparam logic [31:0] ADDR_OFF_X4   = 32'h0000_22D4;

	localparam logic [14:0] GAIN_RST      = 15'h4000;
	localparam logic [14:0] GAIN_UNITY    = 15'h4000;
	localparam logic [14:0] GAIN_ILLEGAL  = 15'h0000;
	localparam logic [14:0] OFF_RST       = 15'h0000;
	localparam logic [14:0] OFF_NONE      = 15'h0000;
	localparam logic [15:0] SAMPLE_MAX    = 16'hFFFF;
	localparam logic [15:0] SAMPLE_MIN    = 16'h0000;

	typedef enum logic [2:0] {
		AGOC_PGA_X1   = 3'h0,
		AGOC_PGA_X1P5 = 3'h1,
		AGOC_PGA_X2   = 3'h2,
		AGOC_PGA_X4   = 3'h3,
		AGOC_PGA_X9   = 3'h4
	} agoc_pga_t;

	typedef enum logic [1:0] {
		AGOC_CH_VOLT = 2'h0,
		AGOC_CH_TIA  = 2'h1,
		AGOC_CH_TEMP = 2'h2
	} agoc_chan_t;
endpackage : agoc_pkg

/* hdl/agoc_cal_if.sv */
// Carries the selected offset and gain codes from the register set to the datapath.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface agoc_cal_if;
	logic [14:0] offset_code;
	logic [14:0] gain_code;

	modport regs (
		output offset_code,
		output gain_code
	);
	modport corr (
		input  offset_code,
		input  gain_code
	);
endinterface : agoc_cal_if

/* hdl/agoc_corr.sv */
// Offset and gain correction of one conversion result per valid cycle.
// Assumes calibration codes arrive already selected for the sample's gain and channel.
`timescale 1ns/10ps
module agoc_corr (
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	agoc_cal_if.corr                  cal,
	input  wire logic                 smp_valid_i,
	input  wire logic [15:0]          smp_data_i,
	output logic                      res_valid_o,
	output logic [15:0]               res_data_o
);
	typedef struct packed {
		logic        valid;
		logic [15:0] data;
	} agoc_corr_st_t;

	agoc_corr_st_t st_r;
	agoc_corr_st_t st_nxt;

	logic signed [agoc_pkg::EXT_W-1:0]              ext_q;
	logic signed [agoc_pkg::EXT_W-1:0]              off_q;
	logic signed [agoc_pkg::EXT_W-1:0]              diff_q;
	logic signed [agoc_pkg::PROD_W-1:0]             prod;
	logic signed [agoc_pkg::PROD_W-agoc_pkg::SCALE_SH-1:0] scaled;

	always_comb begin
		st_nxt = st_r;
		// Result in quarter steps, offset is a signed count of quarter steps.
		ext_q  = $signed({2'h0, smp_data_i, {agoc_pkg::QTR_BITS{1'b0}}});
		off_q  = $signed({{(agoc_pkg::EXT_W-agoc_pkg::CAL_W){cal.offset_code[14]}}, cal.offset_code});
		// Offset is removed before the gain is applied.
		diff_q = ext_q - off_q;
		// Gain code over 16384 scales the result.
		prod   = diff_q * $signed({2'h0, cal.gain_code});
		scaled = prod[agoc_pkg::PROD_W-1:agoc_pkg::SCALE_SH];
		st_nxt.valid = smp_valid_i;
		if (smp_valid_i) begin
			if (cal.gain_code == agoc_pkg::GAIN_ILLEGAL) begin
				st_nxt.data = agoc_pkg::SAMPLE_MIN;
			end else if (scaled < 0) begin
				st_nxt.data = agoc_pkg::SAMPLE_MIN;
			end else if (scaled > $signed({5'h00, agoc_pkg::SAMPLE_MAX})) begin
				st_nxt.data = agoc_pkg::SAMPLE_MAX;
			end else begin
				st_nxt.data = scaled[15:0];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign res_valid_o = st_r.valid;
	assign res_data_o  = st_r.data;
endmodule : agoc_corr

/* hdl/agoc_regs.sv */
// Calibration register set for the ADC result path, with its correction datapath.
// Assumes a classic Wishbone master and conversion results on the same clock.
//
// Operation
// - The gain-4 offset code is applied to results whenever the amplifier gain is 4.
// - Offset codes are two's complement quarter steps, 0x3FFF is +4095.75 and 0x4000 is -4096.
// - Code 0x0001 is +0.25, 0x7FFF is -0.25 and 0x0000 leaves the result alone.
// - The gain-9 offset code, same encoding, is applied whenever the amplifier gain is 9.
// - The gain-4 gain code is used only at gain 4 and never for the TRANSIMPEDANCE_AMPLIFIER or temperature channels.
// - The gain code is an unsigned 15-bit field with an integer bit at 14 and fraction bits 13 to 0.
// - Results are multiplied by the gain code over 16384, so 0x4000 is exactly one.
// - Gain code 0x0000 is illegal for software and forces a corrected result of zero.
// - Reset loads the gain register with 0x4000 and both offset registers with zero.
// - One offset step is a quarter of the result word's least significant bit.
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/10ps
module agoc_regs (
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	input  wire logic                 wb_we_i,
	input  wire logic [31:0]          wb_adr_i,
	input  wire logic [3:0]           wb_sel_i,
	input  wire logic [31:0]          wb_dat_i,
	output logic [31:0]               wb_dat_o,
	output logic                      wb_ack_o,
	input  wire logic [2:0]           pga_gain_i,
	input  wire logic [1:0]           chan_kind_i,
	input  wire logic                 smp_valid_i,
	input  wire logic [15:0]          smp_data_i,
	output logic                      res_valid_o,
	output logic [15:0]               res_data_o
);
	typedef struct packed {
		logic [14:0] gain_x4;
		logic [14:0] off_x9;
		logic [14:0] off_x4;
		logic        ack;
		logic [31:0] rdata;
	} agoc_regs_st_t;

	localparam agoc_regs_st_t ST_RST = '{
		gain_x4: agoc_pkg::GAIN_RST,
		off_x9:  agoc_pkg::OFF_RST,
		off_x4:  agoc_pkg::OFF_RST,
		ack:     1'b0,
		rdata:   32'h0000_0000
	};

	agoc_regs_st_t st_r;
	agoc_regs_st_t st_nxt;

	agoc_cal_if cal ();

	logic        req;
	logic        wr_commit;
	logic [14:0] wmask;
	logic [14:0] rfield;

	assign req       = wb_cyc_i & wb_stb_i;
	assign wr_commit = req & wb_we_i & st_r.ack;
	assign wmask     = {{(agoc_pkg::CAL_W-agoc_pkg::LANE_W){wb_sel_i[1]}}, {agoc_pkg::LANE_W{wb_sel_i[0]}}};

	always_comb begin
		st_nxt = st_r;
		rfield = 15'h0000;
		// One ack per request, dropped in the cycle after it is given.
		st_nxt.ack = req & ~st_r.ack;
		if (wb_adr_i == agoc_pkg::ADDR_GAIN_X4) begin
			rfield = st_r.gain_x4;
		end else if (wb_adr_i == agoc_pkg::ADDR_OFF_X9) begin
			rfield = st_r.off_x9;
		end else if (wb_adr_i == agoc_pkg::ADDR_OFF_X4) begin
			rfield = st_r.off_x4;
		end
		if (req & ~st_r.ack) begin
			st_nxt.rdata = {17'h0_0000, rfield};
		end
		// Writes take effect on the acknowledged edge; only bits 14 to 0 are stored.
		if (wr_commit) begin
			if (wb_adr_i == agoc_pkg::ADDR_GAIN_X4) begin
				st_nxt.gain_x4 = (st_r.gain_x4 & ~wmask) | (wb_dat_i[14:0] & wmask);
			end else if (wb_adr_i == agoc_pkg::ADDR_OFF_X9) begin
				st_nxt.off_x9 = (st_r.off_x9 & ~wmask) | (wb_dat_i[14:0] & wmask);
			end else if (wb_adr_i == agoc_pkg::ADDR_OFF_X4) begin
				st_nxt.off_x4 = (st_r.off_x4 & ~wmask) | (wb_dat_i[14:0] & wmask);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= ST_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign wb_ack_o = st_r.ack;
	assign wb_dat_o = st_r.rdata;

	// Codes follow the current gain and channel.
	always_comb begin
		cal.offset_code = agoc_pkg::OFF_NONE;
		cal.gain_code   = agoc_pkg::GAIN_UNITY;
		case (pga_gain_i)
			agoc_pkg::AGOC_PGA_X4: begin
				cal.offset_code = st_r.off_x4;
				if (chan_kind_i == agoc_pkg::AGOC_CH_VOLT) begin
					cal.gain_code = st_r.gain_x4;
				end
			end
			agoc_pkg::AGOC_PGA_X9: begin
				cal.offset_code = st_r.off_x9;
			end
			default: begin
				cal.offset_code = agoc_pkg::OFF_NONE;
			end
		endcase
	end

	agoc_corr u_corr (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.cal         (cal.corr),
		.smp_valid_i (smp_valid_i),
		.smp_data_i  (smp_data_i),
		.res_valid_o (res_valid_o),
		.res_data_o  (res_data_o)
	);

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// Reset values hold on the first cycle after release.
	rst_vals_a: assert property (@(posedge clk_i) $fell(rst_i) |->
		st_r.gain_x4 == agoc_pkg::GAIN_RST && st_r.off_x4 == agoc_pkg::OFF_RST &&
		st_r.off_x9 == agoc_pkg::OFF_RST)
		else $error("Calibration registers not at reset values.");

	rsvd_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:15] == 17'h0_0000)
		else $error("Reserved bits read nonzero.");

	ack_timing_a: assert property (req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("Ack not a single cycle after the request.");

	off4_write_a: assert property (wr_commit && wb_adr_i == agoc_pkg::ADDR_OFF_X4 && wb_sel_i[1:0] == 2'h3 |=>
		st_r.off_x4 == $past(wb_dat_i[14:0]))
		else $error("Gain-4 offset write not stored.");

	gain4_path_a: assert property (pga_gain_i == agoc_pkg::AGOC_PGA_X4 && chan_kind_i == agoc_pkg::AGOC_CH_VOLT |->
		cal.gain_code == st_r.gain_x4 && cal.offset_code == st_r.off_x4)
		else $error("Gain-4 codes not selected.");

	gain9_path_a: assert property (pga_gain_i == agoc_pkg::AGOC_PGA_X9 |->
		cal.offset_code == st_r.off_x9 && cal.gain_code == agoc_pkg::GAIN_UNITY)
		else $error("Gain-9 codes not selected.");

	tia_unity_a: assert property (chan_kind_i != agoc_pkg::AGOC_CH_VOLT |-> cal.gain_code == agoc_pkg::GAIN_UNITY)
		else $error("Gain code used on a TRANSIMPEDANCE_AMPLIFIER or temperature channel.");

	other_gain_a: assert property (pga_gain_i != agoc_pkg::AGOC_PGA_X4 && pga_gain_i != agoc_pkg::AGOC_PGA_X9 |->
		cal.offset_code == agoc_pkg::OFF_NONE)
		else $error("Offset applied at an uncalibrated gain.");

	zero_gain_a: assert property (smp_valid_i && cal.gain_code == agoc_pkg::GAIN_ILLEGAL |=>
		res_valid_o && res_data_o == agoc_pkg::SAMPLE_MIN)
		else $error("Illegal gain code did not give zero.");

	unity_pass_a: assert property (smp_valid_i && cal.gain_code == agoc_pkg::GAIN_UNITY &&
		(cal.offset_code == agoc_pkg::OFF_NONE || cal.offset_code == 15'h7FFF) |=>
		res_valid_o && res_data_o == $past(smp_data_i))
		else $error("Neutral calibration changed the result.");

	one_lsb_a: assert property (smp_valid_i && cal.gain_code == agoc_pkg::GAIN_UNITY &&
		cal.offset_code == 15'h0004 && smp_data_i != agoc_pkg::SAMPLE_MIN |=>
		res_data_o == $past(smp_data_i) - 16'h0001)
		else $error("Four offset steps did not remove one LSB.");

	half_gain_a: assert property (smp_valid_i && cal.gain_code == 15'h2000 && cal.offset_code == agoc_pkg::OFF_NONE |=>
		res_data_o == {1'b0, $past(smp_data_i[15:1])})
		else $error("Gain code 0x2000 did not halve the result.");

	gain4_smp_c: cover property (smp_valid_i && pga_gain_i == agoc_pkg::AGOC_PGA_X4 ##1 res_valid_o);
	gain9_smp_c: cover property (smp_valid_i && pga_gain_i == agoc_pkg::AGOC_PGA_X9 ##1 res_valid_o);
	gain_wr_c:   cover property (wr_commit && wb_adr_i == agoc_pkg::ADDR_GAIN_X4);
endmodule : agoc_regs

/* test/agoc_regs_tb.sv */
// Self-checking bench for the calibration register set and its correction path.
// Assumes the design answers each Wishbone request within 50 cycles of taking it.
`timescale 1ns/10ps
module agoc_regs_tb;
	logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o, rd;
	logic [3:0]  wb_sel_i = 4'h0;
	logic        wb_ack_o, smp_valid_i = 1'b0, res_valid_o;
	logic [2:0]  pga_gain_i = 3'h0;
	logic [1:0]  chan_kind_i = 2'h0;
	logic [15:0] smp_data_i = 16'h0, res_data_o;
	logic [14:0] o4 = 15'h0, o9 = 15'h0, g4 = 15'h4000;
	logic [14:0] oc [5] = '{15'h3FFF, 15'h0001, 15'h0000, 15'h7FFF, 15'h4000};
	logic [14:0] gc [4] = '{15'h2000, 15'h4000, 15'h7FFF, 15'h0000};
	int          num_errors = 0, checks = 0;
	agoc_regs dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.pga_gain_i(pga_gain_i), .chan_kind_i(chan_kind_i), .smp_valid_i(smp_valid_i), .smp_data_i(smp_data_i),
		.res_valid_o(res_valid_o), .res_data_o(res_data_o));
	initial begin
		forever #4 clk_i = ~clk_i;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic bus(input logic we, input logic [31:0] adr, input logic [31:0] dat, input logic [3:0] sel);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		wb_sel_i <= sel;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (n >= 50) chk(32'h0, 32'h1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
	endtask : bus
	task automatic rdchk(input logic [31:0] adr, input logic [31:0] exp);
		bus(1'b0, adr, 32'h0, 4'hF);
		chk(rd, exp);
	endtask : rdchk
	function automatic logic [15:0] model(logic [2:0] pg, logic [1:0] ch, logic [15:0] s);
		longint off, gn, q;
		off = 0;
		gn  = 16384;
		if (pg == agoc_pkg::AGOC_PGA_X4) begin
			off = longint'($signed(o4));
			if (ch == agoc_pkg::AGOC_CH_VOLT) gn = longint'(g4);
		end else if (pg == agoc_pkg::AGOC_PGA_X9) off = longint'($signed(o9));
		q = (4 * longint'(s) - off) * gn;
		if (q <= 0) return 16'h0000;
		q = q >>> 16;
		return (q > 65535) ? 16'hFFFF : q[15:0];
	endfunction : model
	task automatic smp(input logic [2:0] pg, input logic [1:0] ch, input logic [15:0] s);
		@(posedge clk_i);
		pga_gain_i  <= pg;
		chan_kind_i <= ch;
		smp_data_i  <= s;
		smp_valid_i <= 1'b1;
		@(posedge clk_i);
		smp_valid_i <= 1'b0;
		@(posedge clk_i);
		chk({31'h0, res_valid_o}, 32'h1);
		chk({16'h0, res_data_o}, {16'h0, model(pg, ch, s)});
	endtask : smp
	task automatic do_reset();
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		o4 = 15'h0;
		o9 = 15'h0;
		g4 = 15'h4000;
	endtask : do_reset
	task automatic test_done();
		$display("checks=%0d num_errors=%0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : test_done
	initial begin
		#(8 * 20000);
		num_errors++;
		test_done();
	end
	initial begin
		do_reset();
		rdchk(agoc_pkg::ADDR_GAIN_X4, 32'h0000_4000);
		rdchk(agoc_pkg::ADDR_OFF_X9, 32'h0000_0000);
		rdchk(agoc_pkg::ADDR_OFF_X4, 32'h0000_0000);
		rdchk(32'h0000_2274, 32'h0000_0000);
		$display("test reset values done");
		bus(1'b1, agoc_pkg::ADDR_OFF_X9, 32'hFFFF_FFFF, 4'hF);
		rdchk(agoc_pkg::ADDR_OFF_X9, 32'h0000_7FFF);
		bus(1'b1, agoc_pkg::ADDR_GAIN_X4, 32'hFFFF_00FF, 4'h1);
		rdchk(agoc_pkg::ADDR_GAIN_X4, 32'h0000_40FF);
		$display("test reserved bits and lanes done");
		bus(1'b1, agoc_pkg::ADDR_GAIN_X4, 32'h0000_4000, 4'hF);
		foreach (oc[i]) begin
			bus(1'b1, agoc_pkg::ADDR_OFF_X4, {17'h0, oc[i]}, 4'hF);
			bus(1'b1, agoc_pkg::ADDR_OFF_X9, {17'h0, oc[4 - i]}, 4'hF);
			o4 = oc[i];
			o9 = oc[4 - i];
			smp(agoc_pkg::AGOC_PGA_X4, agoc_pkg::AGOC_CH_VOLT, 16'h1000);
			smp(agoc_pkg::AGOC_PGA_X9, agoc_pkg::AGOC_CH_VOLT, 16'h1000);
		end
		$display("test offset codes done");
		bus(1'b1, agoc_pkg::ADDR_OFF_X4, 32'h0000_0004, 4'hF);
		o4 = 15'h0004;
		foreach (gc[i]) begin
			bus(1'b1, agoc_pkg::ADDR_GAIN_X4, {17'h0, gc[i]}, 4'hF);
			g4 = gc[i];
			smp(agoc_pkg::AGOC_PGA_X4, agoc_pkg::AGOC_CH_VOLT, 16'h1234);
			smp(agoc_pkg::AGOC_PGA_X4, agoc_pkg::AGOC_CH_VOLT, 16'hFFFF);
			smp(agoc_pkg::AGOC_PGA_X4, agoc_pkg::AGOC_CH_TIA, 16'h1234);
			smp(agoc_pkg::AGOC_PGA_X4, agoc_pkg::AGOC_CH_TEMP, 16'h1234);
			smp(agoc_pkg::AGOC_PGA_X1, agoc_pkg::AGOC_CH_VOLT, 16'h1234);
		end
		bus(1'b1, agoc_pkg::ADDR_OFF_X4, 32'h0000_0000, 4'hF);
		bus(1'b1, agoc_pkg::ADDR_GAIN_X4, 32'h0000_2000, 4'hF);
		o4 = 15'h0000;
		g4 = 15'h2000;
		smp(agoc_pkg::AGOC_PGA_X4, agoc_pkg::AGOC_CH_VOLT, 16'h1235);
		$display("test gain codes done");
		do_reset();
		rdchk(agoc_pkg::ADDR_GAIN_X4, 32'h0000_4000);
		rdchk(agoc_pkg::ADDR_OFF_X9, 32'h0000_0000);
		rdchk(agoc_pkg::ADDR_OFF_X4, 32'h0000_0000);
		smp(agoc_pkg::AGOC_PGA_X4, agoc_pkg::AGOC_CH_VOLT, 16'h0ABC);
		$display("test second reset done");
		test_done();
	end
endmodule : agoc_regs_tb
